/* File: rtl/cmms_top.sv */
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module cmms_top
    import cmms_pkg::*;
#(
    parameter int NUM_OBJ = NUM_OBJ_DEF
)(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    input  wire logic        rx_frame_valid,
    input  wire logic [28:0] rx_id,
    input  wire logic        rx_rtr,
    input  wire logic        rx_ide,
    output var  logic        match_valid,
    output var  logic [2:0]  match_object
);
    // ========================================
    // reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ========================================
    // state
    cmms_bus_t   bus_state;
    logic [2:0]  page_obj;
    logic        page_ainc;
    logic [2:0]  page_idx;
    logic [15:0] ts_count;
    logic        last_hit;
    logic [31:0] mask_word [NUM_OBJ];
    logic [31:0] tag_word  [NUM_OBJ];
    logic        obj_ide   [NUM_OBJ];
    logic [15:0] stamp     [NUM_OBJ];

    // ========================================
    // bus decode
    wire logic        bus_req;
    wire logic        access_done;
    wire logic        wr_en;
    wire logic [7:0]  wbyte;
    wire logic        sel_page;
    wire logic        sel_tag;
    wire logic        sel_msk;
    wire logic        sel_stml;
    wire logic        sel_stmh;
    wire logic        sel_msg;
    wire logic        sel_cfg;
    wire logic        sel_stat;
    wire logic [1:0]  tag_lane;
    wire logic [1:0]  msk_lane;
    wire logic        obj_ok;
    wire logic [31:0] cur_mask;
    wire logic [31:0] cur_tag;
    wire logic        cur_ide;
    wire logic [15:0] cur_stamp;
    wire logic [7:0]  rd_byte;
    wire logic [7:0]  msg_rdata;

    assign bus_req     = avs_read | avs_write;
    assign access_done = (bus_state == BUS_ACK) && bus_req;
    assign wr_en       = access_done && avs_write && avs_byteenable[0];
    assign wbyte       = avs_writedata[7:0];

    assign sel_page = avs_address == OFS_PAGE;
    assign sel_tag  = (avs_address >= OFS_TAG4) && (avs_address <= OFS_TAG1)
                      && (avs_address[1:0] == 2'b00);
    assign sel_msk  = (avs_address >= OFS_MSK4) && (avs_address <= OFS_MSK1)
                      && (avs_address[1:0] == 2'b00);
    assign sel_stml = avs_address == OFS_STML;
    assign sel_stmh = avs_address == OFS_STMH;
    assign sel_msg  = avs_address == OFS_MSG;
    assign sel_cfg  = avs_address == OFS_CFG;
    assign sel_stat = avs_address == OFS_STAT;

    // byte4 holds bits 7:0, byte1 holds bits 31:24
    assign tag_lane = 2'((avs_address - OFS_TAG4) >> 2);
    assign msk_lane = 2'((avs_address - OFS_MSK4) >> 2);

    // ========================================
    // selected object view
    assign obj_ok    = int'(page_obj) < NUM_OBJ;
    assign cur_mask  = obj_ok ? mask_word[page_obj] : WORD_RST;
    assign cur_tag   = obj_ok ? tag_word[page_obj] : WORD_RST;
    assign cur_ide   = obj_ok ? obj_ide[page_obj] : 1'b0;
    assign cur_stamp = obj_ok ? stamp[page_obj] : STMP_RST;

    assign rd_byte =
        sel_page ? {1'b0, page_obj, page_ainc, page_idx} :
        sel_tag  ? cur_tag[8*tag_lane +: 8] :
        sel_msk  ? cur_mask[8*msk_lane +: 8] :
        sel_stml ? cur_stamp[7:0] :
        sel_stmh ? cur_stamp[15:8] :
        sel_msg  ? msg_rdata :
        sel_cfg  ? {7'h00, cur_ide} :
        sel_stat ? {4'h0, match_object, last_hit} :
                   8'h00;

    // ========================================
    // avalon answer: one wait cycle, then ready
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_state       <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= WORD_RST;
        end else if (bus_state == BUS_IDLE && bus_req) begin
            bus_state       <= BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h00_0000, rd_byte};
        end else begin
            bus_state       <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end
    end

    // ========================================
    // page register and data index
    wire logic msg_access;

    assign msg_access = access_done && sel_msg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            page_obj  <= 3'h0;
            page_ainc <= 1'b0;
            page_idx  <= 3'h0;
        end else if (wr_en && sel_page) begin
            page_obj  <= wbyte[PAGE_OBJ_LSB +: OBJ_W];
            page_ainc <= wbyte[PAGE_AINC];
            page_idx  <= wbyte[PAGE_IDX_LSB +: IDX_W];
        end else if (msg_access && page_ainc) begin
            page_idx  <= page_idx + 3'h1;
        end
    end

    // ========================================
    // message byte buffer
    cmms_buf_if bif ();

    assign bif.obj   = page_obj;
    assign bif.idx   = page_idx;
    assign bif.we    = wr_en && sel_msg;
    assign bif.wdata = wbyte;
    assign msg_rdata = bif.rdata;

    cmms_msgbuf #(
        .NUM_OBJ (NUM_OBJ)
    ) u_msgbuf (
        .clock (clock),
        .bif   (bif)
    );

    // ========================================
    // time stamp counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ts_count <= STMP_RST;
        end else begin
            ts_count <= ts_count + 16'h0001;
        end
    end

    // ========================================
    // received identifier in mask word layout
    wire logic [31:0] rx_word;

    assign rx_word = rx_ide
        ? {rx_id, rx_rtr, 2'b00}
        : {rx_id[10:0], 18'h0_0000, rx_rtr, 2'b00};

    // ========================================
    // per object registers and filters
    wire logic [NUM_OBJ-1:0] hits;
    wire logic [NUM_OBJ-1:0] first_hit;

    assign first_hit = hits & (~hits + NUM_OBJ'(1));

    genvar g;
    generate
        for (g = 0; g < NUM_OBJ; g++) begin : g_obj
            wire logic this_obj;

            cmms_match_if mif ();

            assign this_obj      = page_obj == OBJ_W'(g);
            assign mif.rx_word   = rx_word;
            assign mif.rx_ide    = rx_ide;
            assign mif.tag_word  = tag_word[g];
            assign mif.mask_word = mask_word[g];
            assign mif.obj_ide   = obj_ide[g];
            assign hits[g]       = mif.hit;

            cmms_accept u_accept (
                .mif (mif)
            );

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    mask_word[g] <= WORD_RST;
                end else if (wr_en && sel_msk && this_obj) begin
                    mask_word[g][8*msk_lane +: 8] <= wbyte;
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    tag_word[g] <= WORD_RST;
                end else if (wr_en && sel_tag && this_obj) begin
                    tag_word[g][8*tag_lane +: 8] <= wbyte;
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    obj_ide[g] <= 1'b0;
                end else if (wr_en && sel_cfg && this_obj) begin
                    obj_ide[g] <= wbyte[0];
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    stamp[g] <= STMP_RST;
                end else if (rx_frame_valid && first_hit[g]) begin
                    stamp[g] <= ts_count;
                end
            end
        end
    endgenerate

    // ========================================
    // match report, lowest object wins
    logic [2:0] hit_index;

    always_comb begin
        hit_index = 3'h0;
        for (int i = NUM_OBJ - 1; i >= 0; i--) begin
            if (hits[i]) begin
                hit_index = 3'(i);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            match_valid  <= 1'b0;
            match_object <= 3'h0;
            last_hit     <= 1'b0;
        end else begin
            match_valid <= rx_frame_valid && (|hits);
            if (rx_frame_valid) begin
                last_hit     <= |hits;
                match_object <= hit_index;
            end
        end
    end
endmodule
`default_nettype wire

/* File: pkg/cmms_pkg.sv */
// Summary of operation
// - standard mask field sits at bits 31:21
// - mask bit 0 forces true, 1 compares
// - remote request mask at bit 2
// - extension flag mask at bit 0
// - extended mask field sits at bits 31:3
// - read-only 16-bit time stamp, two bytes
// - byte window reaches selected object's data byte
// - page write immediately retargets the byte window
// - auto-increment index after each window access
// - data index wraps modulo eight, never stops
// - standard tag field sits at bits 31:21
`default_nettype none
package cmms_pkg;
    // ========================================
    // sizes
    localparam int NUM_OBJ_DEF = 6;
    localparam int DATA_BYTES  = 8;
    localparam int OBJ_W       = 3;
    localparam int IDX_W       = 3;
    // ========================================
    // register byte offsets
    localparam logic [7:0] OFS_PAGE = 8'h00;
    localparam logic [7:0] OFS_TAG4 = 8'h04;
    localparam logic [7:0] OFS_TAG3 = 8'h08;
    localparam logic [7:0] OFS_TAG2 = 8'h0C;
    localparam logic [7:0] OFS_TAG1 = 8'h10;
    localparam logic [7:0] OFS_MSK4 = 8'h14;
    localparam logic [7:0] OFS_MSK3 = 8'h18;
    localparam logic [7:0] OFS_MSK2 = 8'h1C;
    localparam logic [7:0] OFS_MSK1 = 8'h20;
    localparam logic [7:0] OFS_STML = 8'h24;
    localparam logic [7:0] OFS_STMH = 8'h28;
    localparam logic [7:0] OFS_MSG  = 8'h2C;
    localparam logic [7:0] OFS_CFG  = 8'h30;
    localparam logic [7:0] OFS_STAT = 8'h34;
    // ========================================
    // page register fields
    localparam int PAGE_IDX_LSB = 0;
    localparam int PAGE_AINC    = 3;
    localparam int PAGE_OBJ_LSB = 4;
    // ========================================
    // mask and tag word fields
    localparam logic [31:0] STD_ID_FIELD = 32'hFFE0_0000;
    localparam logic [31:0] EXT_ID_FIELD = 32'hFFFF_FFF8;
    localparam logic [31:0] RTR_FIELD    = 32'h0000_0004;
    localparam logic [31:0] IDE_FIELD    = 32'h0000_0001;
    localparam int          STD_ID_LSB   = 21;
    localparam int          EXT_ID_LSB   = 3;
    localparam int          RTR_BIT      = 2;
    // ========================================
    // reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [15:0] STMP_RST = 16'h0000;
    // ========================================
    // bus answer states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } cmms_bus_t;
endpackage
`default_nettype wire

/* File: pkg/cmms_if.sv */
`timescale 1ns/10ps
`default_nettype none
// ========================================
// one object's acceptance comparison
interface cmms_match_if;
    logic [31:0] rx_word;
    logic [31:0] tag_word;
    logic [31:0] mask_word;
    logic        obj_ide;
    logic        rx_ide;
    logic        hit;
    modport filt (input rx_word, tag_word, mask_word, obj_ide, rx_ide, output hit);
    modport ctrl (output rx_word, tag_word, mask_word, obj_ide, rx_ide, input hit);
endinterface

// ========================================
// message byte buffer port
interface cmms_buf_if;
    logic [2:0] obj;
    logic [2:0] idx;
    logic       we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport mem  (input obj, idx, we, wdata, output rdata);
    modport ctrl (output obj, idx, we, wdata, input rdata);
endinterface
`default_nettype wire

/* File: rtl/cmms_accept.sv */
`timescale 1ns/10ps
`default_nettype none
module cmms_accept
    import cmms_pkg::*;
(
    cmms_match_if.filt mif
);
    wire logic [31:0] id_field;
    wire logic [31:0] enabled;
    wire logic [31:0] rx_cmp;
    wire logic [31:0] tag_cmp;

    // ========================================
    // field selection by format
    assign id_field = mif.obj_ide ? EXT_ID_FIELD : STD_ID_FIELD;
    assign enabled  = mif.mask_word & (id_field | RTR_FIELD | IDE_FIELD);
    // extension bit compares against the object's own format
    assign rx_cmp   = {mif.rx_word[31:1], mif.rx_ide};
    assign tag_cmp  = {mif.tag_word[31:1], mif.obj_ide};
    assign mif.hit  = &(~enabled | ~(rx_cmp ^ tag_cmp));
endmodule
`default_nettype wire

/* File: rtl/cmms_msgbuf.sv */
`timescale 1ns/10ps
`default_nettype none
module cmms_msgbuf
    import cmms_pkg::*;
#(
    parameter int NUM_OBJ = NUM_OBJ_DEF
)(
    input  wire logic   clock,
    cmms_buf_if.mem     bif
);
    localparam int DEPTH = NUM_OBJ * DATA_BYTES;
    localparam int AW    = $clog2(DEPTH);

    logic [7:0] store [DEPTH];

    wire logic          obj_ok;
    wire logic [AW-1:0] addr;

    // ========================================
    // object plus index addressing
    assign obj_ok    = int'(bif.obj) < NUM_OBJ;
    assign addr      = AW'(int'(bif.obj) * DATA_BYTES + int'(bif.idx));
    assign bif.rdata = obj_ok ? store[addr] : 8'h00;

    always_ff @(posedge clock) begin
        if (bif.we && obj_ok) begin
            store[addr] <= bif.wdata;
        end
    end
endmodule
`default_nettype wire

/* File: tb/cmms_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module cmms_chk
    import cmms_pkg::*;
#(
    parameter int NUM_OBJ = NUM_OBJ_DEF
)(
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        rx_frame_valid,
    input wire logic [28:0] rx_id,
    input wire logic        rx_rtr,
    input wire logic        rx_ide,
    input wire logic        match_valid,
    input wire logic [2:0]  match_object
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ========================================
    // register bus answer
    property p_ans_next;
        $rose(avs_read) || $rose(avs_write) |=> !avs_waitrequest;
    endproperty
    a_ans_next: assert property (p_ans_next) else $error("no answer after one wait");
    property p_ans_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ans_one: assert property (p_ans_one) else $error("answer longer than a cycle");
    property p_ans_req;
        !avs_waitrequest |-> avs_read || avs_write;
    endproperty
    a_ans_req: assert property (p_ans_req) else $error("answer without request");
    property p_rd_byte;
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
    endproperty
    a_rd_byte: assert property (p_rd_byte) else $error("read data above byte");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address == 8'h3C |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // ========================================
    // frame match
    property p_hit_cause;
        match_valid |-> $past(rx_frame_valid);
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("match without frame");
    property p_obj_hold;
        !$past(rx_frame_valid) |-> $stable(match_object);
    endproperty
    a_obj_hold: assert property (p_obj_hold) else $error("object moved without frame");
    property p_obj_range;
        match_valid |-> int'(match_object) < NUM_OBJ;
    endproperty
    a_obj_range: assert property (p_obj_range) else $error("object out of range");
endmodule
`default_nettype wire

/* File: tb/cmms_node.sv */
`timescale 1ns/10ps
`default_nettype none
module cmms_node (
    input  wire logic        clock,
    output var  logic        rx_frame_valid,
    output var  logic [28:0] rx_id,
    output var  logic        rx_rtr,
    output var  logic        rx_ide
);
    initial begin
        rx_frame_valid = 1'b0;
        rx_id = 29'h0000_0000;
        rx_rtr = 1'b0;
        rx_ide = 1'b0;
    end
    // one-cycle frame, then lines show the inverse
    task automatic send(input logic [28:0] id, input logic rtr, input logic ide);
        @(posedge clock);
        rx_frame_valid <= 1'b1;
        rx_id <= id;
        rx_rtr <= rtr;
        rx_ide <= ide;
        @(posedge clock);
        rx_frame_valid <= 1'b0;
        rx_id <= ~id;
        rx_rtr <= ~rtr;
        rx_ide <= ~ide;
    endtask
endmodule
`default_nettype wire

/* File: tb/can_mob_mask_stamp_data_access_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module can_mob_mask_stamp_data_access_bench;
    import cmms_pkg::*;
    logic        clock;
    logic        rstn;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rx_frame_valid;
    logic [28:0] rx_id;
    logic        rx_rtr;
    logic        rx_ide;
    logic        match_valid;
    logic [2:0]  match_object;
    int          n_mismatch;
    int          checked;
    int          seed;
    int          cyc;
    logic [31:0] rq[$];
    logic [2:0]  mq[$];
    logic [7:0]  bytes[8];
    cmms_top #(.NUM_OBJ(NUM_OBJ_DEF)) cmms_top_inst (.clock(clock), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_frame_valid(rx_frame_valid), .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_ide(rx_ide),
        .match_valid(match_valid), .match_object(match_object));
    cmms_node cmms_node_inst (.clock(clock), .rx_frame_valid(rx_frame_valid),
        .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_ide(rx_ide));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ========================================
    // checks and bus cycles
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (rq.size() != 0 || mq.size() != 0) n_mismatch++;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_read <= ~wr;
        avs_write <= wr;
        if (!wr) rq.push_back({24'h00_0000, d});
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        // released lines show the inverse
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~{24'h00_0000, d};
    endtask
    task automatic word(input logic wr, input logic [7:0] base, input logic [31:0] w);
        for (int k = 0; k < 4; k++) bus(wr, base + 8'(4 * k), w[8 * k +: 8]);
    endtask
    // ========================================
    // monitor
    always @(posedge clock) cyc <= cyc + 1;
    always @(posedge clock) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            check("readdata", avs_readdata, rq.pop_front());
        if (match_valid === 1'b1)
            check("match_object", 32'(match_object), 32'(mq.pop_front()));
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        tally_and_finish();
    end
    // ========================================
    // scenarios
    initial begin
        logic        cfg;
        logic        rr;
        logic        ide;
        logic        hit;
        logic [28:0] rid;
        logic [31:0] fld, m, tw, rw, flip;
        logic [15:0] ts;
        logic [2:0]  lo;
        seed = 32217;
        n_mismatch = 0;
        checked = 0;
        rstn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h1;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        word(1'b0, OFS_MSK4, 32'h0000_0000);
        word(1'b0, OFS_TAG4, 32'h0000_0000);
        // stamp of a never-matched object ignores writes
        bus(1'b1, OFS_PAGE, 8'h50);
        bus(1'b1, OFS_STML, 8'hA5);
        bus(1'b1, OFS_STMH, 8'h5A);
        bus(1'b0, OFS_STML, 8'h00);
        bus(1'b0, OFS_STMH, 8'h00);
        // example bit timing bytes land on unmapped words
        bus(1'b1, 8'h38, 8'h02);
        bus(1'b1, 8'h3C, 8'h04);
        bus(1'b1, 8'h3C, 8'h13);
        bus(1'b0, 8'h3C, 8'h00);
        // object 1, auto-increment from index 6 across the wrap
        bus(1'b1, OFS_PAGE, 8'h1E);
        avs_byteenable <= 4'hE;
        bus(1'b1, OFS_MSK4, 8'hFF);
        avs_byteenable <= 4'h1;
        bus(1'b0, OFS_MSK4, 8'h00);
        for (int k = 0; k < 8; k++) begin
            bytes[k] = 8'($random(seed));
            bus(1'b1, OFS_MSG, bytes[k]);
        end
        bus(1'b1, OFS_PAGE, 8'h1E);
        for (int k = 0; k < 8; k++) bus(1'b0, OFS_MSG, bytes[k]);
        bus(1'b1, OFS_PAGE, 8'h12);
        bus(1'b0, OFS_MSG, bytes[4]);
        bus(1'b0, OFS_MSG, bytes[4]);
        // acceptance on object 0; object 1 keeps an open mask
        for (int it = 0; it < 24; it++) begin
            cfg = 1'($random(seed));
            fld = cfg ? 32'hFFFF_FFFD : 32'hFFE0_0005;
            m = $random(seed) & fld;
            tw = $random(seed) & fld & 32'hFFFF_FFFE;
            flip = $random(seed) & $random(seed) & $random(seed);
            rid = (cfg ? tw[31:3] : {18'h0_0000, tw[31:21]}) ^ flip[28:0];
            rr = tw[2] ^ flip[29];
            ide = cfg ^ flip[30];
            // received word is laid out by the received format
            rw = ide ? {rid, rr, 2'b00} : {rid[10:0], 18'h0_0000, rr, 2'b00};
            hit = (((rw ^ tw) & m & 32'hFFFF_FFFC) == 32'h0000_0000) && (!m[0] || ide == cfg);
            bus(1'b1, OFS_PAGE, 8'h00);
            bus(1'b1, OFS_CFG, {7'h00, cfg});
            word(1'b1, OFS_TAG4, tw);
            word(1'b0, OFS_TAG4, tw);
            word(1'b1, OFS_MSK4, m);
            word(1'b0, OFS_MSK4, m);
            lo = hit ? 3'h0 : 3'h1;
            mq.push_back(lo);
            cmms_node_inst.send(rid, rr, ide);
            // stamp counter starts two edges after reset lifts
            ts = 16'(cyc - 8);
        end
        // stamp and status of the object that took the last frame
        bus(1'b1, OFS_PAGE, {1'b0, lo, 4'h0});
        bus(1'b0, OFS_STML, ts[7:0]);
        bus(1'b0, OFS_STMH, ts[15:8]);
        bus(1'b0, OFS_STAT, {4'h0, lo, 1'b1});
        repeat (4) @(posedge clock);
        tally_and_finish();
    end
endmodule
bind cmms_top cmms_chk #(.NUM_OBJ(NUM_OBJ)) cmms_chk_inst (.clock(clock), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_frame_valid(rx_frame_valid), .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_ide(rx_ide),
    .match_valid(match_valid), .match_object(match_object));
`default_nettype wire
